// ### hdl/lapb_receive_ready_control.sv
// Purpose: receiver-ready status, init-bit sampling and table pointers
// Assumes: host control bits arrive as pins from another clock domain
// Notes: segment ready flag is fetched by the memory side, same clock
`timescale 1ns/1ps
module lapb_receive_ready_control
   import lapb_rr_pkg::*;
#(
   parameter int SEQ_WIDTH = SEQ_W   // Sequence number width
) (
   input wire logic clk,                        // 250 MHz clock
   input wire logic rst_b,                      // Sync reset, active low
   input wire logic ce,                         // Clock enable
   input wire logic manual_disconnect,          // Host disconnect bit (pin)
   input wire logic rx_init_request,            // Host receiver-init bit (pin)
   input wire logic rx_table_test_mode,         // Host test mode bit (pin)
   input wire logic link_up,                    // Link in information transfer
   input wire link_evt_t link_evt,              // Link event pulses
   input wire tx_evt_t tx_evt,                  // Transmit event pulses
   input wire logic rx_segment_ready_flag,      // Ready flag of next segment
   input wire logic [SEQ_WIDTH-1:0] test_entry_ptr, // Pointer load value in test mode
   input wire logic test_entry_load,            // Load pulse in test mode
   input wire logic tx_busy,                    // A packet is being sent
   output logic rx_not_ready_status,            // Receiver-not-ready status
   output logic rx_not_ready_irq,               // Interrupt pulse
   output logic [1:0] irq_error_code,           // Error code with interrupt
   output logic rnr_send,                       // Request an RNR frame
   output logic store_ifield,                   // I-field may enter memory
   output logic check_seq,                      // Check N(S) and N(R)
   output logic [SEQ_WIDTH-1:0] vr,             // Receive sequence V(R)
   output logic [SEQ_WIDTH-1:0] vs,             // Send sequence V(S)
   output logic [SEQ_WIDTH-1:0] rx_next_entry_ptr, // Receive table pointer
   output logic [SEQ_WIDTH-1:0] tx_next_block_ptr, // Transmit next block
   output logic [SEQ_WIDTH-1:0] tx_next_ack_ptr    // Oldest unacknowledged
);
   if (SEQ_WIDTH < 3 || SEQ_WIDTH > 7) begin : g_bad_width
      $error("SEQ_WIDTH must be 3 to 7");
   end

   ////////////////////////////////////////////////////////////////////////
   // Host bits come over pins from another domain
   logic disc_s;
   logic init_s;
   logic test_mode_s;

   // Disconnect idles high, so its filter starts high to avoid a false release
   pin_sync #(.RST_VAL(DISC_RST)) u_sync_disc (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .d(manual_disconnect),
      .q(disc_s)
   );

   pin_sync #(.RST_VAL(1'b0)) u_sync_init (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .d(rx_init_request),
      .q(init_s)
   );

   pin_sync #(.RST_VAL(1'b0)) u_sync_test (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .d(rx_table_test_mode),
      .q(test_mode_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sampling control of the init bit
   typedef enum logic [1:0] {RX_DISC, RX_ARMED, RX_READY, RX_NOT_READY} rx_state_t;
   rx_state_t state_q;
   rx_state_t state_d;
   logic disc_prev_q;
   logic link_reset;
   logic sample_now;
   logic segment_bad;
   logic became_nr;
   logic nr_event;

   // Disconnect comes out of reset set, as a master reset would leave it
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         disc_prev_q <= DISC_RST;
      end else if (ce) begin
         disc_prev_q <= disc_s;
      end
   end

   assign link_reset = link_evt.link_reset_tx | link_evt.link_reset_rx;

   // Sample on disconnect release, set-up, reset, and while not ready
   always_comb begin
      sample_now = 1'b0;
      if (!disc_s) begin
         if (disc_prev_q || link_evt.link_setup || link_reset) begin
            sample_now = 1'b1;
         end else if (state_q == RX_NOT_READY || state_q == RX_ARMED) begin
            sample_now = link_evt.frame_rx;
         end
      end
   end

   // Segment looks unusable unless host asked for init and it is ready
   assign segment_bad = !rx_segment_ready_flag || !init_s;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         RX_DISC: begin
            if (sample_now) begin
               state_d = segment_bad ? RX_NOT_READY : RX_READY;
            end
         end
         RX_ARMED, RX_READY, RX_NOT_READY: begin
            if (disc_s) begin
               state_d = RX_DISC;
            end else if (sample_now) begin
               // A reset with the init bit clear forces not ready
               state_d = segment_bad ? RX_NOT_READY : RX_READY;
            end else if (state_q == RX_READY && link_evt.frame_rx
                         && !rx_segment_ready_flag) begin
               state_d = RX_NOT_READY;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= RX_DISC;
      end else if (ce) begin
         state_q <= state_d;
      end
   end

   assign became_nr = (state_d == RX_NOT_READY) && (state_q != RX_NOT_READY);
   // A fresh sample counts even when already not ready, e.g. after a link reset
   assign nr_event = (state_d == RX_NOT_READY) && (sample_now || state_q != RX_NOT_READY);

   ////////////////////////////////////////////////////////////////////////
   // Status and interrupt, updated in the sampling cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rx_not_ready_status <= 1'b0;
      end else if (ce) begin
         rx_not_ready_status <= (state_d == RX_NOT_READY);
      end
   end

   // Interrupt only when host asked for init but segment is not ready
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rx_not_ready_irq <= 1'b0;
         irq_error_code <= 2'h0;
      end else if (ce) begin
         rx_not_ready_irq <= nr_event && init_s && !rx_segment_ready_flag;
         if (nr_event && init_s && !rx_segment_ready_flag) begin
            irq_error_code <= ERR_RX_NOT_READY;
         end
      end
   end

   // RNR request waits for the packet in flight to end
   logic rnr_pend_q;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rnr_pend_q <= 1'b0;
      end else if (ce) begin
         if (became_nr) begin
            rnr_pend_q <= 1'b1;
         end else if (!tx_busy || state_q != RX_NOT_READY) begin
            rnr_pend_q <= 1'b0;
         end
      end
   end

   assign rnr_send = rnr_pend_q && !tx_busy && link_up;

   // Sequence checks continue while not ready; only storage stops
   assign store_ifield = (state_q == RX_READY) && !rx_not_ready_status;
   assign check_seq = link_evt.iframe_rx;

   ////////////////////////////////////////////////////////////////////////
   // Sequence variables and table pointers
   logic [SEQ_WIDTH-1:0] entry_q;
   logic [SEQ_WIDTH-1:0] retx_ptr_q;
   logic retx_q;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         vr <= SEQ_WIDTH'(SEQ_RST);
      end else if (ce) begin
         if (link_evt.link_setup) begin
            vr <= SEQ_WIDTH'(SEQ_RST);
         end else if (link_evt.pkt_rx_ok && store_ifield) begin
            vr <= vr + SEQ_WIDTH'(1);
         end
      end
   end

   // Pointer held or host-loaded, free of V(R), only under test mode with link up
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         entry_q <= SEQ_WIDTH'(SEQ_RST);
      end else if (ce) begin
         if (test_mode_s && link_up && test_entry_load) begin
            entry_q <= test_entry_ptr;
         end else if (!(test_mode_s && link_up)) begin
            entry_q <= vr;
         end
      end
   end

   // Outside test mode with link up, pointer follows V(R) combinationally so it never lags
   assign rx_next_entry_ptr = (test_mode_s && link_up) ? entry_q : vr;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         vs <= SEQ_WIDTH'(SEQ_RST);
         tx_next_ack_ptr <= SEQ_WIDTH'(SEQ_RST);
      end else if (ce) begin
         if (link_evt.link_setup) begin
            vs <= SEQ_WIDTH'(SEQ_RST);
            tx_next_ack_ptr <= SEQ_WIDTH'(SEQ_RST);
         end else begin
            if (tx_evt.new_pkt_sent) begin
               vs <= vs + SEQ_WIDTH'(1);
            end
            if (tx_evt.ack_one && tx_next_ack_ptr != vs) begin
               tx_next_ack_ptr <= tx_next_ack_ptr + SEQ_WIDTH'(1);
            end
         end
      end
   end

   // Retransmission walks its own pointer from the oldest packet
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         retx_q <= 1'b0;
         retx_ptr_q <= SEQ_WIDTH'(SEQ_RST);
      end else if (ce) begin
         if (link_evt.link_setup) begin
            retx_q <= 1'b0;
         end else if (tx_evt.retx_start) begin
            retx_q <= (tx_next_ack_ptr != vs);
            retx_ptr_q <= tx_next_ack_ptr;
         end else if (retx_q && tx_evt.retx_sent) begin
            retx_ptr_q <= retx_ptr_q + SEQ_WIDTH'(1);
            retx_q <= (retx_ptr_q + SEQ_WIDTH'(1)) != vs;
         end
      end
   end

   assign tx_next_block_ptr = retx_q ? retx_ptr_q : vs;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_entry_tracks_vr: assert property (@(posedge clk) disable iff (!rst_b)
      !(test_mode_s && link_up) |-> rx_next_entry_ptr == vr)
      else $error("receive pointer differs from V(R)");

   a_block_is_vs: assert property (@(posedge clk) disable iff (!rst_b)
      !retx_q |-> tx_next_block_ptr == vs)
      else $error("next block differs from V(S)");

   a_ack_advance: assert property (@(posedge clk) disable iff (!rst_b)
      ce && !link_evt.link_setup && tx_evt.ack_one && tx_next_ack_ptr != vs
      |=> tx_next_ack_ptr == $past(tx_next_ack_ptr) + SEQ_WIDTH'(1))
      else $error("ack pointer did not advance");

   a_ready_no_sample: assert property (@(posedge clk) disable iff (!rst_b)
      ce && state_q == RX_READY && !disc_s && !disc_prev_q && !link_evt.link_setup
      && !link_reset && !link_evt.frame_rx |=> state_q == RX_READY)
      else $error("ready state left without cause");

   a_reset_forces_nr: assert property (@(posedge clk) disable iff (!rst_b)
      ce && !disc_s && link_reset && !init_s |=> rx_not_ready_status)
      else $error("reset with init clear left receiver ready");

   a_irq_no_init: assert property (@(posedge clk) disable iff (!rst_b)
      ce && !init_s |=> !rx_not_ready_irq)
      else $error("interrupt raised with init bit clear");

   a_irq_on_sample: assert property (@(posedge clk) disable iff (!rst_b)
      ce && sample_now && init_s && !rx_segment_ready_flag
      |=> rx_not_ready_irq && rx_not_ready_status)
      else $error("sample with empty segment raised no interrupt");

   a_irq_code: assert property (@(posedge clk) disable iff (!rst_b)
      rx_not_ready_irq |-> rx_not_ready_status && irq_error_code == ERR_RX_NOT_READY)
      else $error("interrupt without status or wrong code");

   a_no_store_nr: assert property (@(posedge clk) disable iff (!rst_b)
      rx_not_ready_status |-> !store_ifield)
      else $error("I-field stored while not ready");

   a_rnr_timely: assert property (@(posedge clk) disable iff (!rst_b)
      ce && became_nr && !tx_busy && link_up ##1 ce && !tx_busy && link_up
      && state_q == RX_NOT_READY |-> rnr_send)
      else $error("RNR not requested while idle");
endmodule : lapb_receive_ready_control

// ### hdl/lapb_rr_pkg.sv
// Purpose: shared types and constants for the receive-ready control block
// Assumes: 3-bit LAPB sequence numbers (modulo 8)
// Notes: event inputs arrive as one-cycle pulses from logic on the same clock
package lapb_rr_pkg;
   localparam int SEQ_W = 3;
   localparam logic [SEQ_W-1:0] SEQ_RST = 3'h0;
   localparam logic [1:0] ERR_RX_NOT_READY = 2'h2; // Error code 10
   localparam int SYNC_STAGES = 3;
   localparam logic DISC_RST = 1'b1; // Disconnect bit is set by a master reset

   // Link events reported by the frame engine
   typedef struct packed {
      logic link_setup;      // Link came up (UA for SABM)
      logic link_reset_tx;   // Link-resetting SABM sent
      logic link_reset_rx;   // Link-resetting SABM received
      logic frame_rx;        // Packet or S-frame received
      logic pkt_rx_ok;       // Packet accepted (in sequence, good FCS)
      logic iframe_rx;       // Any frame with an I-field arrived
   } link_evt_t;

   // Transmit-side protocol events
   typedef struct packed {
      logic new_pkt_sent;    // A new packet finished sending
      logic ack_one;         // Oldest outstanding packet acknowledged
      logic retx_start;      // Retransmission from the oldest begins
      logic retx_sent;       // One retransmitted packet finished
   } tx_evt_t;
endpackage : lapb_rr_pkg

// ### hdl/pin_sync.sv
// Purpose: three-flop synchroniser for a level from a pin
// Assumes: single clock, synchronous active-low reset
// Notes: output changes only once the second and third flops agree; the reset
// level is a parameter so a pin that idles high shows no false edge after reset
`timescale 1ns/1ps
module pin_sync #(
   parameter logic RST_VAL = 1'b0   // Level assumed through reset
) (
   input wire logic clk,     // Clock
   input wire logic rst_b,   // Reset, active low
   input wire logic ce,      // Clock enable
   input wire logic d,       // Asynchronous level
   output logic q            // Filtered level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
      end else if (ce) begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         q <= RST_VAL;
      end else if (ce && (s2_q == s3_q)) begin
         q <= s3_q;
      end
   end
endmodule : pin_sync

// ### testbench/remote_station_model.sv
// Purpose: far-end LAPB station model that emits link event pulses
// Assumes: each event lasts one clock and is launched at the falling edge
// Notes: link_up and the transmit side are left to the bench
`timescale 1ns/1ps
module remote_station_model
   import lapb_rr_pkg::*;
(
   input wire logic clk,       // Clock
   output link_evt_t link_evt  // Event pulses to the block
);
   initial begin
      link_evt = '0;
   end

   // Always returns to idle, so a stale pulse is never seen twice
   task automatic pulse(input link_evt_t e);
      @(negedge clk);
      link_evt = e;
      @(negedge clk);
      link_evt = '0;
   endtask : pulse
endmodule : remote_station_model

// ### testbench/lapb_receive_ready_control_tb.sv
// Purpose: directed bench for receiver-ready control and table pointers
// Assumes: inputs change at the falling edge; host pins need 4 edges to settle
// Notes: test mode pointer is compared only after a host load, which fixes its value
`timescale 1ns/1ps
module lapb_receive_ready_control_tb;
   import lapb_rr_pkg::*;
   localparam logic [5:0] E_PKT = 6'h07;
   localparam logic [5:0] E_FRAME = 6'h04;
   localparam logic [5:0] E_RST_RX = 6'h08;
   localparam logic [5:0] E_RST_TX = 6'h10;
   logic clk = 1'b0;
   logic rst_b, ce, md, init_req, test_mode, link_up, seg_rdy, entry_load, tx_busy;
   logic nr_status, nr_irq, rnr_send, store_ifield, check_seq;
   logic [1:0] err_code;
   logic [SEQ_W-1:0] entry_val, vr, vs, entry_ptr, block_ptr, ack_ptr;
   tx_evt_t tx_evt;
   link_evt_t link_evt;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;

   always #2 clk = ~clk;

   remote_station_model i_remote_station_model (.clk(clk), .link_evt(link_evt));

   lapb_receive_ready_control i_lapb_receive_ready_control (
      .clk(clk), .rst_b(rst_b), .ce(ce), .manual_disconnect(md),
      .rx_init_request(init_req), .rx_table_test_mode(test_mode), .link_up(link_up),
      .link_evt(link_evt), .tx_evt(tx_evt), .rx_segment_ready_flag(seg_rdy),
      .test_entry_ptr(entry_val), .test_entry_load(entry_load), .tx_busy(tx_busy),
      .rx_not_ready_status(nr_status), .rx_not_ready_irq(nr_irq),
      .irq_error_code(err_code), .rnr_send(rnr_send), .store_ifield(store_ifield),
      .check_seq(check_seq), .vr(vr), .vs(vs), .rx_next_entry_ptr(entry_ptr),
      .tx_next_block_ptr(block_ptr), .tx_next_ack_ptr(ack_ptr));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   task automatic host(input logic d, input logic i, input logic f);
      @(negedge clk);
      md = d;
      init_req = i;
      seg_rdy = f;
   endtask : host

   // Pins cross a 3-flop synchroniser, so let them settle
   task automatic settle;
      repeat (4) @(negedge clk);
   endtask : settle

   task automatic wait_irq;
      int n;
      for (n = 0; n < 8 && nr_irq !== 1'b1; n++) @(negedge clk);
   endtask : wait_irq

   task automatic ev(input logic [5:0] e);
      i_remote_station_model.pulse(link_evt_t'(e));
   endtask : ev

   task automatic txp(input logic [3:0] t);
      @(negedge clk);
      tx_evt = tx_evt_t'(t);
      @(negedge clk);
      tx_evt = '0;
   endtask : txp

   // Sample a not-ready event: status and interrupt are judged in the cycle after it
   task automatic not_ready_by(input logic [5:0] e, input logic irq_exp, input string what);
      ev(e);
      check(4'(nr_status), 4'h1, what);
      check(nr_irq, {3'h0, irq_exp}, what);
   endtask : not_ready_by

   task automatic make_ready;
      host(1'b0, 1'b1, 1'b1);
      settle();
      ev(E_FRAME);
      check(4'(nr_status), 4'h0, "status cleared by frame");
   endtask : make_ready

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_b = 1'b0;
      ce = 1'b1;
      md = 1'b1;
      init_req = 1'b0;
      test_mode = 1'b0;
      link_up = 1'b1;
      seg_rdy = 1'b0;
      entry_load = 1'b0;
      entry_val = 3'h0;
      tx_busy = 1'b0;
      tx_evt = '0;
      repeat (5) @(negedge clk);
      check({1'b0, nr_status, nr_irq, rnr_send}, 4'h0, "outputs in reset");
      check(4'(vs), 4'h0, "vs in reset");
      rst_b = 1'b1;
      settle();
      check(4'(nr_status), 4'h0, "no sample while disconnected");
      $display("test reset done");

      // Disconnect clears with init set and segment empty
      host(1'b1, 1'b1, 1'b0);
      settle();
      host(1'b0, 1'b1, 1'b0);
      wait_irq();
      check(4'(nr_irq), 4'h1, "irq on disconnect clear");
      check({2'h0, err_code}, {2'h0, ERR_RX_NOT_READY}, "error code");
      check(4'(nr_status), 4'h1, "status on disconnect clear");
      check(4'(store_ifield), 4'h0, "no store while not ready");
      tx_busy = 1'b1;
      #1 check(4'(rnr_send), 4'h0, "rnr held while sending");
      @(negedge clk);
      tx_busy = 1'b0;
      link_up = 1'b0;
      #1 check(4'(rnr_send), 4'h0, "rnr held while link down");
      link_up = 1'b1;
      #1 check(4'(rnr_send), 4'h1, "rnr once idle");
      fork
         ev(6'h01);
         begin
            @(negedge clk);
            #1 check(4'(check_seq), 4'h1, "sequence checked while not ready");
         end
      join
      $display("test disconnect sample done");

      make_ready();
      // Host drops init once packets flow; ready is kept with no new sampling
      host(1'b0, 1'b0, 1'b1);
      settle();
      ev(E_FRAME);
      check(4'(nr_status), 4'h0, "no resample while ready");
      not_ready_by(E_RST_RX, 1'b0, "reset received, init clear");
      make_ready();
      host(1'b0, 1'b0, 1'b1);
      settle();
      not_ready_by(E_RST_TX, 1'b0, "reset sent, init clear");
      host(1'b0, 1'b1, 1'b0);
      settle();
      not_ready_by(E_RST_TX, 1'b1, "reset sent, segment empty");
      make_ready();
      host(1'b0, 1'b1, 1'b0);
      settle();
      ev(E_FRAME);
      check(4'(nr_status), 4'h1, "empty segment at frame");
      make_ready();
      $display("test not ready conditions done");

      repeat (3) ev(E_PKT);
      check(4'(vr), 4'h3, "vr after three packets");
      check(4'(entry_ptr), 4'h3, "entry pointer follows vr");
      @(negedge clk);
      entry_val = 3'h5;
      entry_load = 1'b1;
      @(negedge clk);
      entry_load = 1'b0;
      check(4'(entry_ptr), 4'h3, "load refused outside test mode");
      // Test mode with link up lets the host steer the pointer away from V(R)
      test_mode = 1'b1;
      settle();
      entry_load = 1'b1;
      @(negedge clk);
      entry_load = 1'b0;
      check(4'(entry_ptr), 4'h5, "load taken in test mode");
      ev(E_PKT);
      check(4'(entry_ptr), 4'h5, "pointer free of vr in test mode");
      check(4'(vr), 4'h4, "vr still counts in test mode");
      test_mode = 1'b0;
      settle();
      check(4'(entry_ptr), 4'h4, "pointer back on vr");
      txp(4'h8);
      txp(4'h8);
      check(4'(block_ptr), 4'h2, "next block after two sends");
      check(4'(vs), 4'h2, "vs after two sends");
      ce = 1'b0;
      txp(4'h8);
      ce = 1'b1;
      check(4'(vs), 4'h2, "vs frozen while disabled");
      check(4'(ack_ptr), 4'h0, "oldest unacked");
      txp(4'h4);
      check(4'(ack_ptr), 4'h1, "oldest after one ack");
      txp(4'h2);
      check(4'(block_ptr), 4'h1, "retransmit from oldest");
      txp(4'h1);
      check(4'(block_ptr), 4'h2, "next block back at vs");
      $display("test pointers done");
      test_done();
   end
endmodule : lapb_receive_ready_control_tb
